// ==== pkg/rmul_pkg.sv ====
// Constants and register map for the registered 16x16 multiplier
// Notes on behaviour
// RULE1: Full 32-bit product of both 16-bit operand registers.
// RULE2: Operand A word and its signed select captured on rising edge.
// RULE3: Operand B word and its signed select captured the same way.
// RULE4: Operand registers hold while load-hold-n high, load while low.
// RULE5: Signed select high means two's complement, low means unsigned.
// RULE6: Both signed selects act independently, mixed pairs allowed.
// RULE7: Round control registered only when either operand load enable is low.
// RULE8: Round adds one at lower-half top bit for 16-bit rounding.
// RULE9: Shift select low gives 31-bit product, sign copy at lower top bit.
// RULE10: Shift select high gives unshifted 32-bit product.
// RULE11: Result held in upper and lower 16-bit result registers.
// RULE12: Result registers load while result-load-hold-n low, else hold.
// RULE13: Transparent control high passes product through without edge wait. Here the result and ports still load on the operand capture edge.
// RULE14: Multiplexer steers either half onto the upper output port.
// RULE15: Half select low puts upper half on upper port.
// RULE16: Half select high puts lower half on upper port.
// RULE17: Result MSB given in true and inverted form.
// RULE18: Upper and lower halves driven on separate ports together.
// RULE19: Each output port drives while enabled, else released. MSB pair has no enable here and is always driven.
// RULE20: Driving logic holds operands and controls stable across capture edge.
package rmul_pkg;
    localparam int          OP_W          = 16;
    localparam int          PROD_W        = 32;
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_RESULT   = 8'h04;
    localparam logic [7:0]  ADDR_OPERANDS = 8'h08;
    localparam int          ADDR_W        = 8;
    localparam int          CTRL_W        = 8;
    localparam int          BIT_A_SIGNED  = 0;
    localparam int          BIT_B_SIGNED  = 1;
    localparam int          BIT_ROUND     = 2;
    localparam int          BIT_SHIFT     = 3;
    localparam int          BIT_TRANSP    = 4;
    localparam int          BIT_HALF_SEL  = 5;
    localparam int          BIT_UPPER_OE  = 6;
    localparam int          BIT_LOWER_OE  = 7;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [31:0] ROUND_UNSHIFT = 32'h0000_8000;
    localparam logic [31:0] ROUND_SHIFTED = 32'h0000_4000;
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
endpackage

// ==== rtl/rmul_core.sv ====
// Registered 16x16 multiplier with AHB-Lite control registers
//
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module rmul_core (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Operand and load pins
    input  wire logic [15:0] aOperand,
    input  wire logic [15:0] bOperand,
    input  wire logic        aLoadHoldN,
    input  wire logic        bLoadHoldN,
    input  wire logic        resultLoadHoldN,
    // Result ports, halves three-state as data plus enable, MSB pair always driven
    output logic      [15:0] upperOutputPort,
    output logic             upperOutputOe,
    output logic      [15:0] lowerOutputPort,
    output logic             lowerOutputOe,
    output logic             resultMsb,
    output logic             resultMsbN
);

    typedef struct packed {
        logic [15:0] aReg;
        logic        aSigned;
        logic [15:0] bReg;
        logic        bSigned;
        logic        roundReg;
        logic [15:0] resHi;
        logic [15:0] resLo;
        logic [7:0]  ctrl;
        logic        wrPend;
        logic [7:0]  wrAddr;
        logic [31:0] rdata;
        logic [15:0] upperOut;
        logic        upperOe;
        logic [15:0] lowerOut;
        logic        lowerOe;
        logic        msb;
        logic        msbN;
        logic        ready;
        logic        resp;
    } rmul_state_s;

    rmul_state_s state;
    rmul_state_s next_state;

    // Product of given operands with per-operand sign extension
    function automatic logic [31:0] rmul_product(input logic [15:0] a, input logic sa,
                                                 input logic [15:0] b, input logic sb);
        logic signed [16:0] ea;
        logic signed [16:0] eb;
        logic signed [33:0] p;
        ea = $signed({sa & a[15], a}); // RULE5 RULE6
        eb = $signed({sb & b[15], b}); // RULE5 RULE6
        p  = ea * eb; // RULE1
        return p[31:0];
    endfunction

    logic [31:0] prodRaw;
    logic [31:0] prodRnd;
    logic [15:0] nextHi;
    logic [15:0] nextLo;
    logic        addrPhase;

    always_comb begin
        next_state = state;
        addrPhase  = hsel & hready & (htrans == rmul_pkg::HTRANS_NONSEQ || htrans == rmul_pkg::HTRANS_SEQ);

        // Data phase of a write lands one cycle after its address phase
        next_state.wrPend = addrPhase & hwrite;
        next_state.wrAddr = haddr[7:0];
        if (state.wrPend && state.wrAddr == rmul_pkg::ADDR_CTRL) begin
            next_state.ctrl = hwdata[7:0];
        end

        // Operand capture with their format selects
        if (!aLoadHoldN) begin // RULE4
            next_state.aReg    = aOperand; // RULE2
            next_state.aSigned = state.ctrl[rmul_pkg::BIT_A_SIGNED]; // RULE2
        end
        if (!bLoadHoldN) begin // RULE4
            next_state.bReg    = bOperand; // RULE3
            next_state.bSigned = state.ctrl[rmul_pkg::BIT_B_SIGNED]; // RULE3
        end
        if (!aLoadHoldN || !bLoadHoldN) begin
            next_state.roundReg = state.ctrl[rmul_pkg::BIT_ROUND]; // RULE7
        end

        // Transparent mode feeds the product of the operands being loaded now
        if (state.ctrl[rmul_pkg::BIT_TRANSP]) begin
            prodRaw = rmul_product(next_state.aReg, next_state.aSigned,
                                   next_state.bReg, next_state.bSigned); // RULE13
        end else begin
            prodRaw = rmul_product(state.aReg, state.aSigned, state.bReg, state.bSigned);
        end
        // Rounding lands on the lower-half top bit in either format
        if (!(state.ctrl[rmul_pkg::BIT_TRANSP] ? next_state.roundReg : state.roundReg)) begin
            prodRnd = prodRaw;
        end else if (state.ctrl[rmul_pkg::BIT_SHIFT]) begin
            prodRnd = prodRaw + rmul_pkg::ROUND_UNSHIFT; // RULE8
        end else begin
            prodRnd = prodRaw + rmul_pkg::ROUND_SHIFTED; // RULE8
        end
        if (state.ctrl[rmul_pkg::BIT_SHIFT]) begin
            nextHi = prodRnd[31:16]; // RULE10
            nextLo = prodRnd[15:0]; // RULE10
        end else begin
            nextHi = prodRnd[30:15]; // RULE9
            nextLo = {prodRnd[30], prodRnd[14:0]}; // RULE9
        end
        if (!resultLoadHoldN || state.ctrl[rmul_pkg::BIT_TRANSP]) begin // RULE12 RULE13
            next_state.resHi = nextHi; // RULE11
            next_state.resLo = nextLo; // RULE11
        end

        // Output stage registered so every port comes from a flop
        if (next_state.ctrl[rmul_pkg::BIT_HALF_SEL]) begin
            next_state.upperOut = next_state.resLo; // RULE14 RULE16
        end else begin
            next_state.upperOut = next_state.resHi; // RULE14 RULE15
        end
        next_state.lowerOut = next_state.resLo; // RULE18
        next_state.upperOe  = next_state.ctrl[rmul_pkg::BIT_UPPER_OE]; // RULE19
        next_state.lowerOe  = next_state.ctrl[rmul_pkg::BIT_LOWER_OE]; // RULE19
        next_state.msb      = next_state.resHi[15]; // RULE17
        next_state.msbN     = ~next_state.resHi[15]; // RULE17

        // Zero wait states: slave is ready from the first edge after reset and always OKAY
        next_state.ready = 1'b1;
        next_state.resp  = 1'b0;

        // Read data sampled at the address phase, unmapped reads give zero
        if (addrPhase && !hwrite) begin
            unique case (haddr[7:0])
                rmul_pkg::ADDR_CTRL:     next_state.rdata = {24'h00_0000, state.ctrl};
                rmul_pkg::ADDR_RESULT:   next_state.rdata = {state.resHi, state.resLo};
                rmul_pkg::ADDR_OPERANDS: next_state.rdata = {state.aReg, state.bReg};
                default:                 next_state.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state      <= '0;
            state.ctrl <= rmul_pkg::CTRL_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign hrdata          = state.rdata;
    assign hreadyout       = state.ready;
    assign hresp           = state.resp;
    assign upperOutputPort = state.upperOut;
    assign upperOutputOe   = state.upperOe;
    assign lowerOutputPort = state.lowerOut;
    assign lowerOutputOe   = state.lowerOe;
    assign resultMsb       = state.msb;
    assign resultMsbN      = state.msbN;

endmodule // rmul_core

// ==== tb/rmul_monitor.sv ====
// Port checks for the multiplier core
`timescale 1ns/1ps
module rmul_monitor (
    input wire logic        clk, rstn, hsel, hwrite, hready, hreadyout, hresp,
    input wire logic        aLoadHoldN, bLoadHoldN, resultLoadHoldN,
    input wire logic        upperOutputOe, lowerOutputOe, resultMsb, resultMsbN,
    input wire logic [1:0]  htrans,
    input wire logic [31:0] haddr, hrdata,
    input wire logic [15:0] upperOutputPort, lowerOutputPort
);
    wire logic       rq = hsel && htrans[1] && hready;
    wire logic       wr = rq && hwrite;
    wire logic [8:0] rd = {rq && !hwrite, haddr[7:0]};
    wire logic       held = aLoadHoldN && bLoadHoldN && resultLoadHoldN;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_msb_pair: assert property ($past(rstn) |-> resultMsbN == !resultMsb) else $error("msb pair");
    a_resp_okay: assert property (hresp == 1'h0) else $error("hresp set");
    a_ready_high: assert property ($past(rstn) |-> hreadyout) else $error("hreadyout low");
    // Ctrl writes, operand loads and result loads all move the ports, so any of them opens the window
    a_port_hold: assert property ($past(rstn, 3) && $past(held) && $past(held, 2) && !$past(wr)
        && !$past(wr, 2) && !$past(wr, 3) |-> $stable({upperOutputPort, lowerOutputPort})) else $error("port moved");
    a_oe_stable: assert property ($past(rstn, 3) && !$past(wr) && !$past(wr, 2)
        |-> $stable({upperOutputOe, lowerOutputOe})) else $error("enable moved");
    a_oe_ctrl: assert property ($past(rstn, 3) && $past(rd) == {1'h1, rmul_pkg::ADDR_CTRL} && !$past(wr, 2)
        && !$past(wr, 3) |-> hrdata[7:6] == {lowerOutputOe, upperOutputOe}) else $error("enable vs ctrl");
    a_result_read: assert property ($past(rstn, 2) && $past(rd) == {1'h1, rmul_pkg::ADDR_RESULT}
        |-> hrdata[15:0] == $past(lowerOutputPort)) else $error("result vs port");
    a_unmapped_zero: assert property ($past(rd) == 9'h10C |-> hrdata == 32'h0) else $error("unmapped read");
endmodule // rmul_monitor

bind rmul_core rmul_monitor u_mon (.*);

// ==== tb/rmul_feeder.sv ====
// Operand source standing in for the system datapath
`timescale 1ns/1ps
module rmul_feeder (
    input  wire logic        clk, loadReq,
    input  wire logic [15:0] aIn, bIn,
    output logic      [15:0] aOperand, bOperand,
    output logic             aLoadHoldN, bLoadHoldN
);
    initial {aOperand, bOperand, aLoadHoldN, bLoadHoldN} = {32'h0, 2'h3};
    // Words valid only across the load edge, inverted otherwise so a stray load shows
    always @(posedge clk) begin
        aOperand <= loadReq ? aIn : ~aOperand;
        bOperand <= loadReq ? bIn : ~bOperand;
        {aLoadHoldN, bLoadHoldN} <= {2{!loadReq}};
    end
endmodule // rmul_feeder

// ==== tb/registered_mult_16x16_tb.sv ====
// Self-checking bench for the registered multiplier
`timescale 1ns/1ps
module registered_mult_16x16_tb;
    typedef struct packed {logic [7:0] c; logic [15:0] a, b, hi, lo;} rmul_row_s;
    logic clk = 1'h0, rstn = 1'h0, hsel = 1'h1, hwrite = 1'h0, resultLoadHoldN = 1'h0, loadReq = 1'h0, hready;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [2:0]  hsize = 3'h2;
    logic [1:0]  htrans = 2'h0;
    logic [15:0] aIn = 16'h0, bIn = 16'h0, aOperand, bOperand, upperOutputPort, lowerOutputPort;
    logic        hreadyout, hresp, aLoadHoldN, bLoadHoldN, upperOutputOe, lowerOutputOe, resultMsb, resultMsbN;
    int          nMismatch = 0, totalChecks = 0;
    wire logic [31:0] ports = {upperOutputPort, lowerOutputPort};
    wire logic [31:0] oes = {30'h0, upperOutputOe, lowerOutputOe};
    // Control byte, operands, expected upper and lower halves
    rmul_row_s rows [8] = '{'{8'hCB, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0001},
        '{8'hC9, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0001}, '{8'hCA, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0001},
        '{8'hC3, 16'h4000, 16'h4000, 16'h2000, 16'h0000}, '{8'hCC, 16'h0001, 16'h8000, 16'h0001, 16'h0000},
        '{8'hC7, 16'h0001, 16'h4000, 16'h0001, 16'h0000}, '{8'hC3, 16'hFFFF, 16'h0001, 16'hFFFF, 16'hFFFF},
        '{8'hC8, 16'hFFFF, 16'hFFFF, 16'hFFFE, 16'h0001}};
    assign hready = hreadyout;
    rmul_core DUT (.*);
    rmul_feeder u_feed (.*);
    initial forever #12.5 clk = ~clk;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        htrans <= rmul_pkg::HTRANS_NONSEQ;
        haddr <= {24'h0, ad};
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'h1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'h1) @(posedge clk);
        rd = hrdata;
    endtask
    task automatic run(input logic [7:0] c, input logic [15:0] a, input logic [15:0] b);
        bus(1'h1, rmul_pkg::ADDR_CTRL, {24'h0, c});
        aIn <= a;
        bIn <= b;
        loadReq <= 1'h1;
        @(posedge clk);
        loadReq <= 1'h0;
        repeat (5) @(posedge clk);
    endtask
    task automatic do_reset(input int n);
        rstn <= 1'h0;
        repeat (n) @(posedge clk);
        rstn <= 1'h1;
        repeat (2) @(posedge clk);
    endtask
    task automatic tally_and_finish;
        if (nMismatch == 0 && totalChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Far beyond the roughly 150 cycles the sequence needs
    initial begin
        repeat (4000) @(posedge clk);
        nMismatch++;
        tally_and_finish;
    end
    initial begin
        do_reset(20);
        check("reset ports", ports, 32'h0);
        check("reset enables", oes, 32'h0);
        bus(1'h0, rmul_pkg::ADDR_CTRL, 32'h0);
        check("ctrl reset", rd, {24'h0, rmul_pkg::CTRL_RESET});
        bus(1'h0, 8'h0C, 32'h0);
        check("unmapped", rd, 32'h0);
        foreach (rows[i]) begin
            run(rows[i].c, rows[i].a, rows[i].b);
            check("ports", ports, {rows[i].hi, rows[i].lo});
            check("msb", {30'h0, resultMsb, resultMsbN}, {30'h0, rows[i].hi[15], !rows[i].hi[15]});
            bus(1'h0, rmul_pkg::ADDR_RESULT, 32'h0);
            check("result", rd, {rows[i].hi, rows[i].lo});
        end
        // Round bit written with no operand load must not reach the result
        bus(1'h1, rmul_pkg::ADDR_CTRL, 32'h0000_00CC);
        repeat (2) @(posedge clk);
        check("round unloaded", ports, 32'hFFFE_0001);
        resultLoadHoldN <= 1'h1;
        run(8'hC8, 16'h0101, 16'h0300);
        check("held", ports, 32'hFFFE_0001);
        resultLoadHoldN <= 1'h0;
        repeat (3) @(posedge clk);
        check("loaded", ports, 32'h0003_0300);
        bus(1'h0, rmul_pkg::ADDR_OPERANDS, 32'h0);
        check("operands", rd, 32'h0101_0300);
        run(8'hE8, 16'h0101, 16'h0300);
        check("half select", ports, 32'h0300_0300);
        bus(1'h0, rmul_pkg::ADDR_CTRL, 32'h0);
        check("ctrl readback", rd, 32'h0000_00E8);
        resultLoadHoldN <= 1'h1;
        run(8'hD8, 16'h0002, 16'h0004);
        check("transparent", ports, 32'h0000_0008);
        check("enables on", oes, 32'h3);
        run(8'h08, 16'h0002, 16'h0004);
        check("enables off", oes, 32'h0);
        do_reset(2);
        check("mid reset", ports, 32'h0);
        tally_and_finish;
    end
endmodule // registered_mult_16x16_tb
